// File: rtl/bdm_params.svh
// constants for the banked data memory map
`ifndef BDM_PARAMS_SVH
`define BDM_PARAMS_SVH

// ****************************************************************
// bank layout
// ****************************************************************
`define BDM_BANK_W      5
`define BDM_OFF_W       7
`define BDM_SFR_FIRST   7'h0C
`define BDM_GPR_FIRST   7'h20
`define BDM_COM_FIRST   7'h70
`define BDM_GPR_BYTES   7'd80
`define BDM_COM_BYTES   5'd16
`define BDM_GPR_BANKS   5'd8
`define BDM_RAM_DEPTH   656
`define BDM_RAM_AW      10
`define BDM_COM_BASE    10'd640
`define BDM_GPR_TOTAL   13'd640

// ****************************************************************
// pointer address space
// ****************************************************************
`define BDM_LIN_BASE    16'h2000

// ****************************************************************
// core register offsets
// ****************************************************************
`define BDM_R_IND0      7'h00
`define BDM_R_IND1      7'h01
`define BDM_R_STATUS    7'h03
`define BDM_R_P0L       7'h04
`define BDM_R_P0H       7'h05
`define BDM_R_P1L       7'h06
`define BDM_R_P1H       7'h07
`define BDM_R_BANK      7'h08
`define BDM_R_WREG      7'h09
`define BDM_R_PCLATH    7'h0A

// ****************************************************************
// return stack
// ****************************************************************
`define BDM_STK_DEPTH   5'd16
`define BDM_STK_AW      4
`define BDM_PC_W        15

`endif

// File: rtl/bdm_pkg.sv
// types for the banked data memory map
package bdm_pkg;

    typedef enum logic [2:0] {
        BDM_DIRECT   = 3'b001,
        BDM_INDIRECT = 3'b010,
        BDM_RELATIVE = 3'b100
    } bdm_mode_t;

    typedef struct packed {
        logic       valid;
        logic       write;
        bdm_mode_t  mode;
        logic [6:0] offset;
        logic       ptr_sel;
        logic [5:0] rel;
        logic [7:0] wdata;
    } bdm_req_t;

    typedef struct packed {
        logic       valid;
        logic [7:0] rdata;
    } bdm_rsp_t;

    typedef struct packed {
        logic       strobe;
        logic       write;
        logic [4:0] bank;
        logic [6:0] offset;
        logic [7:0] wdata;
    } bdm_sfr_t;

endpackage

// File: rtl/bdm_ram.sv
// single port storage with registered read data
`timescale 1ns/1ps
`default_nettype none

module bdm_ram #(
    parameter int W  = 8,
    parameter int D  = 16,
    parameter int AW = 4
) (
    // clock and reset
    input  wire logic          clk,
    input  wire logic          reset_n,
    // access
    input  wire logic          we,
    input  wire logic [AW-1:0] addr,
    input  wire logic [W-1:0]  wdata,
    output logic      [W-1:0]  rdata
);

    logic [W-1:0] mem [D];

    always_ff @(posedge clk) begin
        if (we) begin
            mem[addr] <= wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            rdata <= '0;
        end else begin
            rdata <= mem[addr];
        end
    end

endmodule

`default_nettype wire

// File: rtl/bdm_core.sv
// banked data memory map, pointers, return stack and context save
`timescale 1ns/1ps
`default_nettype none
`include "bdm_params.svh"

// Operation
// RQ1: special registers at offsets 0x0C to 0x1F
// RQ2: up to 80 general bytes per bank
// RQ3: 16 common bytes shared by every bank
// RQ4: general RAM linear through the pointers
// RQ5: two pointers reach program and data
// RQ6: 16 deep stack, over/underflow may reset
// RQ7: direct, indirect and relative addressing
// RQ8: context saved on interrupt, restored on return
// RQ9: direct address is bank plus offset
module bdm_core (
    // clock and reset
    input  wire logic                          clk,
    input  wire logic                          reset_n,
    // data access
    input  wire bdm_pkg::bdm_req_t             req,
    output bdm_pkg::bdm_rsp_t                  rsp,
    // special register window
    output bdm_pkg::bdm_sfr_t                  sfr,
    input  wire logic [7:0]                    sfr_rdata,
    // program memory read
    output logic                               prog_rd,
    output logic [14:0]                        prog_addr,
    input  wire logic [13:0]                   prog_rdata,
    // return stack
    input  wire logic                          push,
    input  wire logic                          pop,
    input  wire logic [`BDM_PC_W-1:0]          push_addr,
    output logic [`BDM_PC_W-1:0]               pop_addr,
    output logic                               pop_valid,
    input  wire logic                          stack_reset_en,
    output logic                               stack_reset,
    output logic                               stack_over,
    output logic                               stack_under,
    // interrupt context
    input  wire logic                          int_entry,
    input  wire logic                          int_return,
    output logic [4:0]                         bank_sel
);
    import bdm_pkg::*;

    // ************************************************************
    // architectural core registers
    // ************************************************************
    logic [15:0] ptr [2];
    logic [7:0]  wreg, status, pclath;
    logic [4:0]  bank;
    logic [15:0] s_ptr [2];
    logic [7:0]  s_wreg, s_status, s_pclath;
    logic [4:0]  s_bank;

    // ************************************************************
    // address formation and decode
    // ************************************************************
    logic [15:0]           eff;
    logic [12:0]           lin;
    logic [4:0]            a_bank;
    logic [6:0]            a_off;
    logic                  r_core, r_sfr, r_gpr, r_com, r_prog;
    logic [`BDM_RAM_AW-1:0] ram_addr;
    logic [11:0]           bank_base;

    always_comb begin
        unique case (req.mode)
            BDM_DIRECT:   eff = (req.offset == `BDM_R_IND0 ||
                                 req.offset == `BDM_R_IND1)
                              ? ptr[req.offset[0]]              // RQ7
                              : {4'h0, bank, req.offset};       // RQ9
            BDM_INDIRECT: eff = ptr[req.ptr_sel];               // RQ7
            BDM_RELATIVE: eff = ptr[req.ptr_sel]
                              + {{10{req.rel[5]}}, req.rel};    // RQ7
            default:      eff = 16'h0000;
        endcase
    end

    assign lin       = eff[12:0];
    assign a_bank    = eff[11:7];
    assign a_off     = eff[6:0];
    assign bank_base = {7'h00, a_bank} * 12'(`BDM_GPR_BYTES);

    always_comb begin
        r_core   = 1'b0;
        r_sfr    = 1'b0;
        r_gpr    = 1'b0;
        r_com    = 1'b0;
        r_prog   = 1'b0;
        ram_addr = '0;
        if (eff[15]) begin
            r_prog = 1'b1;                                      // RQ5
        end else if (eff[15:13] == 3'b001) begin
            if (lin < `BDM_GPR_TOTAL) begin
                r_gpr    = 1'b1;                                // RQ4
                ram_addr = lin[`BDM_RAM_AW-1:0];                // RQ4
            end
        end else if (eff[15:12] == 4'h0) begin
            if (a_off < `BDM_SFR_FIRST) begin
                r_core = 1'b1;
            end else if (a_off < `BDM_GPR_FIRST) begin
                r_sfr = 1'b1;                                   // RQ1
            end else if (a_off < `BDM_COM_FIRST) begin
                if (a_bank < `BDM_GPR_BANKS) begin
                    r_gpr    = 1'b1;                            // RQ2
                    ram_addr = bank_base[`BDM_RAM_AW-1:0]
                             + {3'b000, a_off - `BDM_GPR_FIRST};
                end
            end else begin
                r_com    = 1'b1;                                // RQ3
                ram_addr = `BDM_COM_BASE + {6'h00, a_off[3:0]};
            end
        end
    end

    // ************************************************************
    // data storage and outward windows
    // ************************************************************
    logic [7:0] ram_rdata;
    logic       ram_we;
    assign ram_we = req.valid && req.write && (r_gpr || r_com);

    bdm_ram #(.W(8), .D(`BDM_RAM_DEPTH), .AW(`BDM_RAM_AW)) u_data (
        .clk     (clk),
        .reset_n (reset_n),
        .we      (ram_we),
        .addr    (ram_addr),
        .wdata   (req.wdata),
        .rdata   (ram_rdata)
    );

    assign sfr = '{strobe: req.valid && r_sfr, write: req.write, // RQ1
                   bank: a_bank, offset: a_off, wdata: req.wdata};
    assign prog_rd    = req.valid && !req.write && r_prog;      // RQ5
    assign prog_addr  = eff[14:0];
    assign bank_sel   = bank;

    // ************************************************************
    // read answer, one cycle after the request
    // ************************************************************
    logic [7:0] core_rd;
    logic [7:0] side_q;
    logic       use_ram, rsp_valid;

    always_comb begin
        unique case (a_off)
            `BDM_R_STATUS: core_rd = status;
            `BDM_R_P0L:    core_rd = ptr[0][7:0];
            `BDM_R_P0H:    core_rd = ptr[0][15:8];
            `BDM_R_P1L:    core_rd = ptr[1][7:0];
            `BDM_R_P1H:    core_rd = ptr[1][15:8];
            `BDM_R_BANK:   core_rd = {3'b000, bank};
            `BDM_R_WREG:   core_rd = wreg;
            `BDM_R_PCLATH: core_rd = pclath;
            default:       core_rd = 8'h00;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            {rsp_valid, side_q, use_ram} <= '0;
        end else begin
            rsp_valid <= req.valid && !req.write;
            use_ram   <= r_gpr || r_com;
            side_q    <= r_prog ? prog_rdata[7:0] :
                         r_sfr  ? sfr_rdata :
                         r_core ? core_rd : 8'h00;
        end
    end

    assign rsp = '{valid: rsp_valid, rdata: use_ram ? ram_rdata : side_q};

    // ************************************************************
    // core register writes and context save
    // ************************************************************
    logic core_wr;
    assign core_wr = req.valid && req.write && r_core;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            {ptr[0], ptr[1], wreg, status, pclath, bank} <= '0;
        end else if (int_return) begin
            {ptr[0], ptr[1], wreg, status, pclath, bank} <=         // RQ8
                {s_ptr[0], s_ptr[1], s_wreg, s_status, s_pclath, s_bank};
        end else if (core_wr) begin
            unique case (a_off)
                `BDM_R_STATUS: status <= req.wdata;
                `BDM_R_P0L:    ptr[0][7:0]  <= req.wdata;
                `BDM_R_P0H:    ptr[0][15:8] <= req.wdata;
                `BDM_R_P1L:    ptr[1][7:0]  <= req.wdata;
                `BDM_R_P1H:    ptr[1][15:8] <= req.wdata;
                `BDM_R_BANK:   bank   <= req.wdata[4:0];
                `BDM_R_WREG:   wreg   <= req.wdata;
                `BDM_R_PCLATH: pclath <= req.wdata;
                default:       wreg   <= wreg;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            {s_ptr[0], s_ptr[1], s_wreg, s_status, s_pclath, s_bank} <= '0;
        end else if (int_entry) begin
            {s_ptr[0], s_ptr[1], s_wreg, s_status, s_pclath, s_bank} <= // RQ8
                {ptr[0], ptr[1], wreg, status, pclath, bank};
        end
    end

    // ************************************************************
    // return stack
    // ************************************************************
    logic [4:0]             depth;
    logic                   full, empty, do_push, do_pop;
    logic [`BDM_STK_AW-1:0] stk_addr;

    assign full     = (depth == `BDM_STK_DEPTH);
    assign empty    = (depth == 5'd0);
    assign do_push  = push && !full;
    assign do_pop   = pop && !push && !empty;
    assign stk_addr = do_pop ? 4'(depth - 5'd1) : depth[3:0];

    bdm_ram #(.W(`BDM_PC_W), .D(16), .AW(`BDM_STK_AW)) u_stack (
        .clk     (clk),
        .reset_n (reset_n),
        .we      (do_push),
        .addr    (stk_addr),
        .wdata   (push_addr),
        .rdata   (pop_addr)
    );

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            {depth, pop_valid, stack_over, stack_under, stack_reset} <= '0;
        end else begin
            depth       <= depth + {4'h0, do_push} - {4'h0, do_pop};
            pop_valid   <= do_pop;
            stack_over  <= push && full;                        // RQ6
            stack_under <= pop && !push && empty;               // RQ6
            stack_reset <= stack_reset_en &&
                           ((push && full) || (pop && !push && empty));
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    sequence s_ctx_taken;
        int_entry ##1 !int_entry;
    endsequence

    a_sfr_window: assert property (sfr.strobe |->             // RQ1
        sfr.offset >= 7'h0C && sfr.offset <= 7'h1F)
        else $error("special window outside 0x0C..0x1F");
    a_gpr_size: assert property (r_gpr && !eff[13] |->         // RQ2
        a_off - 7'h20 < 7'd80)
        else $error("banked general byte beyond 80");
    a_common_map: assert property (r_com |->                   // RQ3
        ram_addr == 10'd640 + a_off[3:0])
        else $error("common byte depends on bank");
    a_linear_map: assert property (eff[15:13] == 3'b001 &&      // RQ4
        lin < 13'd640 |-> r_gpr && ram_addr == lin[9:0])
        else $error("linear view misplaced");
    a_prog_read: assert property (                              // RQ5
        req.valid && !req.write && eff[15] |-> prog_rd ##1
        rsp.valid && rsp.rdata == $past(prog_rdata[7:0]))
        else $error("program read answer wrong");
    a_stack_over: assert property (                             // RQ6
        push && depth == 5'd16 && stack_reset_en |=> stack_reset)
        else $error("overflow gave no reset");
    a_stack_under: assert property (                            // RQ6
        pop && !push && depth == 5'd0 |=> stack_under && depth == 0)
        else $error("underflow not flagged");
    a_rel_addr: assert property (req.mode == BDM_RELATIVE |->   // RQ7
        eff == ptr[req.ptr_sel] + {{10{req.rel[5]}}, req.rel})
        else $error("relative address wrong");
    a_ctx_save: assert property (s_ctx_taken |->                // RQ8
        s_wreg == $past(wreg) && s_bank == $past(bank))
        else $error("context not saved");
    a_ctx_restore: assert property (int_return |=>              // RQ8
        wreg == $past(s_wreg) && bank == $past(s_bank)
        && ptr[0] == $past(s_ptr[0]))
        else $error("context not restored");
    a_direct_bank: assert property (req.mode == BDM_DIRECT &&   // RQ9
        req.offset > 7'h01 |-> eff[11:7] == bank && eff[6:0] == req.offset)
        else $error("direct address ignores bank");

endmodule

`default_nettype wire

// File: bench/bdm_far_model.sv
// peripheral registers and program memory behind the core
`timescale 1ns/1ps
`default_nettype none

module bdm_far_model (
    // clock
    input  wire logic              clk,
    // special register window
    input  wire bdm_pkg::bdm_sfr_t sfr,
    output logic [7:0]             sfr_rdata,
    // program memory
    input  wire logic              prog_rd,
    input  wire logic [14:0]       prog_addr,
    output logic [13:0]            prog_rdata
);
    import bdm_pkg::*;

    logic [7:0]  regs [0:1023];
    logic [7:0]  last_s;
    logic [13:0] last_p;
    logic [9:0]  idx;

    assign idx = {sfr.bank, sfr.offset[4:0]};

    always @(posedge clk) begin
        if (sfr.strobe && sfr.write) begin
            regs[idx] <= sfr.wdata;
        end
        if (sfr.strobe) begin
            last_s <= sfr_rdata;
        end
        if (prog_rd) begin
            last_p <= prog_rdata;
        end
    end

    // unselected lines show the inverse of the last value
    assign sfr_rdata  = sfr.strobe ? regs[idx] : ~last_s;
    assign prog_rdata = prog_rd ? (prog_addr[13:0] ^ 14'h2A5A) : ~last_p;
endmodule

`default_nettype wire

// File: bench/tb_top.sv
// self-checking bench for the banked data memory map
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import bdm_pkg::*;

    // ****************************************************************
    // signals
    // ****************************************************************
    logic        clk;
    logic        reset_n;
    bdm_req_t    req;
    bdm_rsp_t    rsp;
    bdm_sfr_t    sfr;
    logic [7:0]  sfr_rdata;
    logic        prog_rd;
    logic [14:0] prog_addr;
    logic [13:0] prog_rdata;
    logic        push;
    logic        pop;
    logic [14:0] push_addr;
    logic [14:0] pop_addr;
    logic        pop_valid;
    logic        stack_reset_en;
    logic        stack_reset;
    logic        stack_over;
    logic        stack_under;
    logic        int_entry;
    logic        int_return;
    logic [4:0]  bank_sel;
    int          fail_count;
    int          n_checks;
    integer      seed;
    logic [7:0]  rd_q [$];
    logic [14:0] pop_q [$];
    logic [14:0] stk [0:15];
    logic [7:0]  d1;
    logic [7:0]  d2;
    logic [7:0]  d3;

    bdm_core i_bdm_core (.clk(clk), .reset_n(reset_n), .req(req),
        .rsp(rsp), .sfr(sfr), .sfr_rdata(sfr_rdata), .prog_rd(prog_rd),
        .prog_addr(prog_addr), .prog_rdata(prog_rdata), .push(push),
        .pop(pop), .push_addr(push_addr), .pop_addr(pop_addr),
        .pop_valid(pop_valid), .stack_reset_en(stack_reset_en),
        .stack_reset(stack_reset), .stack_over(stack_over),
        .stack_under(stack_under), .int_entry(int_entry),
        .int_return(int_return), .bank_sel(bank_sel));

    bdm_far_model i_bdm_far_model (.clk(clk), .sfr(sfr),
        .sfr_rdata(sfr_rdata), .prog_rd(prog_rd), .prog_addr(prog_addr),
        .prog_rdata(prog_rdata));

    // ****************************************************************
    // tasks
    // ****************************************************************
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic acc(input logic w, input bdm_mode_t m, input logic [6:0] o,
                       input logic s, input logic [5:0] r, input logic [7:0] d);
        req = '{valid: 1'b1, write: w, mode: m, offset: o, ptr_sel: s,
                rel: r, wdata: d};
        @(negedge clk);
    endtask

    task automatic rd(input bdm_mode_t m, input logic [6:0] o, input logic s,
                      input logic [5:0] r, input logic [7:0] e);
        rd_q.push_back(e);
        acc(1'b0, m, o, s, r, 8'h00);
    endtask

    task automatic rdd(input logic [6:0] o, input logic [7:0] e);
        rd(BDM_DIRECT, o, 1'b0, 6'h00, e);
    endtask

    task automatic wr(input logic [6:0] o, input logic [7:0] d);
        acc(1'b1, BDM_DIRECT, o, 1'b0, 6'h00, d);
    endtask

    task automatic setp(input logic s, input logic [15:0] v);
        wr(7'h04 + {5'h00, s, 1'b0}, v[7:0]);
        wr(7'h05 + {5'h00, s, 1'b0}, v[15:8]);
    endtask

    // idle cycle, then a one cycle strobe on a control input
    task automatic pulse(ref logic s);
        req = '0;
        @(negedge clk);
        s = 1'b1;
        @(negedge clk);
        s = 1'b0;
    endtask

    // ****************************************************************
    // clock, monitors, watchdog
    // ****************************************************************
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    always @(negedge clk) begin
        if (reset_n && rsp.valid === 1'b1) begin
            if (rd_q.size() == 0) begin
                check(16'h0001, 16'h0000);
            end else begin
                check({8'h00, rsp.rdata}, {8'h00, rd_q.pop_front()});
            end
        end
        if (reset_n && pop_valid === 1'b1) begin
            if (pop_q.size() == 0) begin
                check(16'h0002, 16'h0000);
            end else begin
                check({1'b0, pop_addr}, {1'b0, pop_q.pop_front()});
            end
        end
    end

    initial begin
        #200000;
        fail_count++;
        give_verdict();
    end

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        seed = 76509;
        fail_count = 0;
        n_checks = 0;
        reset_n = 1'b0;
        req = '0;
        push = 1'b0;
        pop = 1'b0;
        push_addr = 15'h0000;
        stack_reset_en = 1'b1;
        int_entry = 1'b0;
        int_return = 1'b0;
        d1 = 8'($random(seed));
        d2 = d1 ^ 8'hA5;
        d3 = d1 ^ 8'h3C;
        repeat (10) @(negedge clk);
        reset_n = 1'b1;
        check({11'h000, bank_sel}, 16'h0000);
        rdd(7'h09, 8'h00);
        wr(7'h25, d1);
        rdd(7'h25, d1);
        wr(7'h08, 8'h03);
        wr(7'h25, d2);
        wr(7'h75, d3);
        check({11'h000, bank_sel}, 16'h0003);
        rdd(7'h25, d2);
        wr(7'h08, 8'h00);
        rdd(7'h25, d1);
        rdd(7'h75, d3);
        wr(7'h08, 8'h02);
        wr(7'h0C, d1);
        wr(7'h1F, d2);
        wr(7'h08, 8'h03);
        wr(7'h0C, d3);
        rdd(7'h0C, d3);
        wr(7'h08, 8'h02);
        rdd(7'h0C, d1);
        rdd(7'h1F, d2);
        wr(7'h08, 8'h08);
        wr(7'h30, d1);
        rdd(7'h30, 8'h00);
        wr(7'h08, 8'h01);
        wr(7'h20, d2);
        setp(1'b0, 16'h2050);
        rd(BDM_INDIRECT, 7'h00, 1'b0, 6'h00, d2);
        rdd(7'h00, d2);
        acc(1'b1, BDM_RELATIVE, 7'h00, 1'b0, 6'h3F, d3);
        wr(7'h08, 8'h00);
        rdd(7'h6F, d3);
        setp(1'b1, 16'h01A5);
        rd(BDM_INDIRECT, 7'h00, 1'b1, 6'h00, d2);
        setp(1'b1, 16'h8123);
        rd(BDM_INDIRECT, 7'h00, 1'b1, 6'h00, 8'h79);
        rd(BDM_RELATIVE, 7'h00, 1'b1, 6'h02, 8'h7F);
        wr(7'h09, d1);
        wr(7'h08, 8'h02);
        pulse(int_entry);
        wr(7'h09, d2);
        wr(7'h08, 8'h05);
        wr(7'h06, 8'h11);
        pulse(int_return);
        check({11'h000, bank_sel}, 16'h0002);
        rdd(7'h09, d1);
        rdd(7'h06, 8'h23);
        req = '0;
        push = 1'b1;
        for (int i = 0; i < 16; i++) begin
            stk[i] = 15'($random(seed));
            push_addr = stk[i];
            @(negedge clk);
        end
        push_addr = 15'h7FFF;
        @(negedge clk);
        push = 1'b0;
        check({15'h0000, stack_over}, 16'h0001);
        check({15'h0000, stack_reset}, 16'h0001);
        pop = 1'b1;
        for (int i = 15; i >= 0; i--) begin
            pop_q.push_back(stk[i]);
            @(negedge clk);
        end
        @(negedge clk);
        check({15'h0000, stack_under}, 16'h0001);
        check({15'h0000, stack_reset}, 16'h0001);
        stack_reset_en = 1'b0;
        @(negedge clk);
        pop = 1'b0;
        check({15'h0000, stack_under}, 16'h0001);
        check({15'h0000, stack_reset}, 16'h0000);
        repeat (3) @(negedge clk);
        check(16'(rd_q.size()), 16'h0000);
        check(16'(pop_q.size()), 16'h0000);
        give_verdict();
    end
endmodule

`default_nettype wire
